// File: core/ssw_top.sv
// supply supervisor with reset stretching, strobe watchdog and debounced early-warning flag
// assumes comparator results arrive as digital levels; pins are resolved outside from the enables
`timescale 1ns/1ps
`include "ssw_params.svh"

module ssw_top #(
    parameter logic [31:0] P_TPU_CYC       = 32'(`SSW_TPU_CYC),
    parameter logic [31:0] P_WD_LONG_CYC   = 32'(`SSW_WD_LONG_CYC),
    parameter logic [31:0] P_WD_SHORT_CYC  = 32'(`SSW_WD_SHORT_CYC),
    parameter logic [31:0] P_RST_INT_CYC   = 32'(`SSW_RST_INT_CYC),
    parameter logic [31:0] P_SAMPLE_CYC    = 32'(`SSW_SAMPLE_CYC),
    parameter logic [31:0] P_PB_CYC        = 32'(`SSW_PB_CYC),
    parameter logic [31:0] P_EXT_FIRST     = 32'(`SSW_EXT_FIRST_CLKS),
    parameter logic [31:0] P_EXT_OTHER     = 32'(`SSW_EXT_OTHER_CLKS),
    parameter logic [31:0] P_EXT_RST       = 32'(`SSW_EXT_RST_CLKS)
) (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_supply_ok,
    input  wire logic        i_sense_ok,
    input  wire logic        i_above_battery,
    input  wire logic        i_strobe_n,
    input  wire logic        i_strobe_open,
    input  wire logic        i_osc_input,
    input  wire logic        i_osc_select,
    input  wire logic        i_reset_n_in,
    output logic             o_reset_n_out,
    output logic             o_reset_n_oe,
    output logic             o_reset,
    output logic             o_supply_low_flag,
    output logic             o_watchdog_flag_n,
    output logic             o_nmi_n,
    output logic             o_nmi_oe,
    input  wire logic [3:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [3:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready
);

    ssw_pkg::ssw_state_s q;
    ssw_pkg::ssw_state_s d;

    logic [7:0]  pins;
    logic        sup_ok;
    logic        sense_ok;
    logic        above_bat;
    logic        st_fall;
    logic        tick;
    logic        wd_en;
    logic        wd_fire;
    logic        pb_fire;
    logic        smp_tick;
    logic [31:0] period;
    logic [31:0] pulse_lim;

    // 0 ctrl, 1 status, 2 watchdog count, 3 unmapped
    function automatic logic [1:0] ssw_reg_sel(input logic [3:0] a);
        if (a == `SSW_OFF_CTRL) begin
            return 2'h0;
        end else if (a == `SSW_OFF_STATUS) begin
            return 2'h1;
        end else if (a == `SSW_OFF_WDCNT) begin
            return 2'h2;
        end else begin
            return 2'h3;
        end
    endfunction

    assign pins = {i_reset_n_in, i_osc_select, i_osc_input, i_strobe_open,
                   i_strobe_n, i_above_battery, i_sense_ok, i_supply_ok};

    assign sup_ok    = q.filt[`SSW_IN_SUP];
    assign sense_ok  = q.filt[`SSW_IN_SENSE];
    assign above_bat = q.filt[`SSW_IN_BAT];
    assign st_fall   = q.strobe_prev & ~q.filt[`SSW_IN_STROBE];
    // external mode advances only on rising edges of the supplied clock
    assign tick      = q.mode_ext ? (q.filt[`SSW_IN_OSC_INPUT] & ~q.osc_prev) : 1'b1;
    assign wd_en     = ~q.filt[`SSW_IN_OPEN] & ~q.wd_dis & sup_ok;
    assign smp_tick  = (q.smp_cnt + 32'h0000_0001) >= P_SAMPLE_CYC;

    always_comb begin
        if (q.mode_ext) begin
            period = q.first ? P_EXT_FIRST : P_EXT_OTHER;
        end else if (q.mode_osc_in) begin
            period = P_WD_LONG_CYC;
        end else begin
            period = q.first ? P_WD_LONG_CYC : P_WD_SHORT_CYC;
        end
        if (q.pu) begin
            pulse_lim = P_TPU_CYC;
        end else if (q.mode_ext) begin
            pulse_lim = P_EXT_RST;
        end else begin
            pulse_lim = P_RST_INT_CYC;
        end
    end

    // strobe edge takes priority over an expiry in the same cycle
    assign wd_fire = (q.state == ssw_pkg::SSW_RUN) && wd_en && !st_fall && tick && !q.force_req && !pb_fire
                     && ((q.wd_cnt + 32'h0000_0001) >= period);
    assign pb_fire = (q.state == ssw_pkg::SSW_RUN) && sup_ok && !q.filt[`SSW_IN_RSTPIN]
                     && ((q.pb_cnt + 32'h0000_0001) >= P_PB_CYC);

    always_comb begin
        d = q;
        // three-stage synchroniser, value taken once stages two and three agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 8; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s2[i];
            end
        end
        d.strobe_prev = q.filt[`SSW_IN_STROBE];
        d.osc_prev    = q.filt[`SSW_IN_OSC_INPUT];
        // oscillator pins float below battery level, so keep the last mode
        if (above_bat) begin
            d.mode_ext    = ~q.filt[`SSW_IN_OSC_SELECT];
            d.mode_osc_in = q.filt[`SSW_IN_OSC_INPUT];
        end

        if (q.state == ssw_pkg::SSW_RUN && !q.filt[`SSW_IN_RSTPIN]) begin
            d.pb_cnt = q.pb_cnt + 32'h0000_0001;
        end else begin
            d.pb_cnt = 32'h0000_0000;
        end

        case (q.state)
            ssw_pkg::SSW_SUPPLY_LOW: begin
                d.wd_cnt = 32'h0000_0000;
                if (sup_ok) begin
                    d.state     = ssw_pkg::SSW_PULSE;
                    d.pu        = 1'b1;
                    d.pulse_cnt = 32'h0000_0000;
                end
            end
            ssw_pkg::SSW_PULSE: begin
                d.wd_cnt = 32'h0000_0000;
                if (!sup_ok) begin
                    d.state = ssw_pkg::SSW_SUPPLY_LOW;
                end else if (q.pu || tick) begin
                    if ((q.pulse_cnt + 32'h0000_0001) >= pulse_lim) begin
                        d.state = ssw_pkg::SSW_RUN;
                        d.first = 1'b1;
                    end else begin
                        d.pulse_cnt = q.pulse_cnt + 32'h0000_0001;
                    end
                end
            end
            ssw_pkg::SSW_RUN: begin
                if (!sup_ok) begin
                    d.state  = ssw_pkg::SSW_SUPPLY_LOW;
                    d.wd_cnt = 32'h0000_0000;
                end else if (q.force_req || pb_fire) begin
                    d.state     = ssw_pkg::SSW_PULSE;
                    d.pu        = 1'b0;
                    d.pulse_cnt = 32'h0000_0000;
                    d.wd_cnt    = 32'h0000_0000;
                    d.force_req = 1'b0;
                end else if (!wd_en) begin
                    d.wd_cnt = 32'h0000_0000;
                end else if (st_fall) begin
                    d.wd_cnt = 32'h0000_0000;
                    d.first  = 1'b0;
                end else if (wd_fire) begin
                    d.state     = ssw_pkg::SSW_PULSE;
                    d.pu        = 1'b0;
                    d.pulse_cnt = 32'h0000_0000;
                    d.wd_cnt    = 32'h0000_0000;
                end else if (tick) begin
                    d.wd_cnt = q.wd_cnt + 32'h0000_0001;
                end
            end
            default: begin
                d.state = ssw_pkg::SSW_SUPPLY_LOW;
            end
        endcase

        // release first, then the setting terms override
        if (st_fall || q.filt[`SSW_IN_OPEN]) begin
            d.wdflag_n = 1'b1;
        end
        if (wd_fire) begin
            d.wdflag_n = 1'b0;
        end
        if (!sup_ok) begin
            d.wdflag_n = 1'b0;
        end
        d.rst_act    = (d.state != ssw_pkg::SSW_RUN);
        d.supply_low = ~sup_ok;

        // early-warning sampling, time-domain hysteresis
        d.smp_cnt = smp_tick ? 32'h0000_0000 : (q.smp_cnt + 32'h0000_0001);
        if (sup_ok) begin
            d.powered = 1'b1;
        end else if (!above_bat) begin
            d.powered = 1'b0;
        end
        if (sense_ok) begin
            d.low_cnt = 2'h0;
            d.nmi_n   = 1'b1;
        end else if (smp_tick && q.low_cnt != 2'h3) begin
            d.low_cnt = q.low_cnt + 2'h1;
        end
        if (!sense_ok && d.low_cnt == 2'h3 && q.powered) begin
            d.nmi_n = 1'b0;
        end
        d.nmi_oe = above_bat;

        // register slave: address and data in either order, response after both
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            d.aw_got = 1'b1;
            d.awaddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            d.w_got  = 1'b1;
            d.wbits  = i_s_axi_wdata[1:0];
            d.wstrb0 = i_s_axi_wstrb[0];
        end
        if (q.bvalid && i_s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `SSW_RESP_OKAY;
            if (ssw_reg_sel(q.awaddr) == 2'h0) begin
                if (q.wstrb0) begin
                    d.wd_dis = q.wbits[`SSW_CTRL_WDDIS_BIT];
                    // a write request wins over the consume in the same cycle
                    if (q.wbits[`SSW_CTRL_FORCE_BIT]) begin
                        d.force_req = 1'b1;
                    end
                end
            end else if (ssw_reg_sel(q.awaddr) == 2'h3) begin
                d.bresp = `SSW_RESP_SLVERR;
            end
        end
        if (q.rvalid && i_s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `SSW_RESP_OKAY;
            d.rdata  = 32'h0000_0000;
            if (ssw_reg_sel(i_s_axi_araddr) == 2'h0) begin
                d.rdata[`SSW_CTRL_WDDIS_BIT] = q.wd_dis;
            end else if (ssw_reg_sel(i_s_axi_araddr) == 2'h1) begin
                d.rdata[7:0] = {1'b0, q.powered, q.first, q.nmi_n, q.wdflag_n, q.rst_act, q.supply_low, 1'b0};
            end else if (ssw_reg_sel(i_s_axi_araddr) == 2'h2) begin
                d.rdata = q.wd_cnt;
            end else begin
                d.rresp = `SSW_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            q             <= '0;
            q.s1          <= `SSW_IN_RST_VAL;
            q.s2          <= `SSW_IN_RST_VAL;
            q.s3          <= `SSW_IN_RST_VAL;
            q.filt        <= `SSW_IN_RST_VAL;
            q.strobe_prev <= 1'b1;
            q.state       <= ssw_pkg::SSW_SUPPLY_LOW;
            q.wdflag_n    <= 1'b0;
            q.rst_act     <= 1'b1;
            q.supply_low  <= 1'b1;
            q.nmi_n       <= 1'b1;
            q.mode_ext    <= 1'b0;
            q.wd_dis      <= `SSW_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    assign o_reset           = q.rst_act;
    assign o_reset_n_out     = 1'b0;
    assign o_reset_n_oe      = q.rst_act;
    assign o_supply_low_flag = q.supply_low;
    assign o_watchdog_flag_n = q.wdflag_n;
    assign o_nmi_n           = q.nmi_n;
    assign o_nmi_oe          = q.nmi_oe;
    assign o_s_axi_awready   = ~q.aw_got & ~q.bvalid;
    assign o_s_axi_wready    = ~q.w_got & ~q.bvalid;
    assign o_s_axi_bvalid    = q.bvalid;
    assign o_s_axi_bresp     = q.bresp;
    assign o_s_axi_arready   = ~q.rvalid;
    assign o_s_axi_rvalid    = q.rvalid;
    assign o_s_axi_rdata     = q.rdata;
    assign o_s_axi_rresp     = q.rresp;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    supply_low_a: assert property (!sup_ok |=> o_supply_low_flag && o_reset)
        else $error("supply low did not force flag and reset");
    supply_back_a: assert property (sup_ok |=> !o_supply_low_flag)
        else $error("supply low flag stayed after recovery");
    reset_stretch_a: assert property ($fell(o_supply_low_flag) |-> o_reset [*4])
        else $error("reset released too soon after supply return");
    count_start_a: assert property ($fell(o_reset) |-> q.wd_cnt == 32'h0000_0000)
        else $error("watchdog count not zero at reset release");
    strobe_restart_a: assert property (q.state == ssw_pkg::SSW_RUN && wd_en && st_fall
                                       |=> q.wd_cnt == 32'h0000_0000)
        else $error("strobe edge did not restart the count");
    wd_timeout_a: assert property (wd_fire |=> !o_watchdog_flag_n && o_reset)
        else $error("expiry did not drive flag and reset");
    flag_hold_a: assert property (!o_watchdog_flag_n && !st_fall && !q.filt[`SSW_IN_OPEN]
                                  |=> !o_watchdog_flag_n)
        else $error("watchdog flag released without cause");
    flag_release_a: assert property (st_fall && sup_ok |=> o_watchdog_flag_n)
        else $error("strobe edge did not release flag");
    wd_open_a: assert property (q.state == ssw_pkg::SSW_RUN && q.filt[`SSW_IN_OPEN]
                                |=> q.wd_cnt == 32'h0000_0000)
        else $error("watchdog counted with strobe open");
    flag_low_a: assert property (!sup_ok |=> !o_watchdog_flag_n)
        else $error("watchdog flag high during low supply");
    nmi_three_a: assert property ($fell(o_nmi_n) |-> q.low_cnt == 2'h3 && !$past(sense_ok))
        else $error("warning without three low samples");
    nmi_block_a: assert property ($fell(o_nmi_n) |-> $past(q.powered))
        else $error("warning raised before supply reached trip");
    nmi_release_a: assert property (sense_ok |=> o_nmi_n)
        else $error("warning not released on recovery");
    pb_reset_a: assert property (pb_fire |=> o_reset ##1 o_reset)
        else $error("pushbutton did not give reset");
    osc_frozen_a: assert property (!above_bat |=> $stable(q.mode_ext) && $stable(q.mode_osc_in))
        else $error("oscillator mode changed below battery level");

    wd_fire_c: cover property (wd_fire);
    nmi_c: cover property ($fell(o_nmi_n));
    pb_c: cover property (pb_fire);
    release_c: cover property ($fell(o_reset));

endmodule // ssw_top

// File: pkg/ssw_params.svh
// constants of the supply supervisor and watchdog: offsets, fields, reset values, timing counts
// assumes a 250 MHz timing clock; long counts become module parameters fed from these
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

`define SSW_CLK_MHZ        250
`define SSW_TPU_MS         100
`define SSW_TPU_CYC        (`SSW_TPU_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_LONG_MS     2700
`define SSW_WD_LONG_CYC    (`SSW_WD_LONG_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_SHORT_MS    170
`define SSW_WD_SHORT_CYC   (`SSW_WD_SHORT_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_RST_INT_MS     85
`define SSW_RST_INT_CYC    (`SSW_RST_INT_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_SAMPLE_NS      33000
`define SSW_SAMPLE_CYC     (`SSW_SAMPLE_NS * `SSW_CLK_MHZ / 1000)
`define SSW_PB_MS          30
`define SSW_PB_CYC         (`SSW_PB_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_EXT_FIRST_CLKS 20480
`define SSW_EXT_OTHER_CLKS 5120
`define SSW_EXT_RST_CLKS   641

`define SSW_OFF_CTRL       4'h0
`define SSW_OFF_STATUS     4'h4
`define SSW_OFF_WDCNT      4'h8
`define SSW_CTRL_WDDIS_BIT 0
`define SSW_CTRL_FORCE_BIT 1
`define SSW_CTRL_RST       1'b0
`define SSW_RESP_OKAY      2'h0
`define SSW_RESP_SLVERR    2'h2

// synchroniser lanes
`define SSW_IN_SUP         0
`define SSW_IN_SENSE       1
`define SSW_IN_BAT         2
`define SSW_IN_STROBE      3
`define SSW_IN_OPEN        4
`define SSW_IN_OSC_INPUT       5
`define SSW_IN_OSC_SELECT      6
`define SSW_IN_RSTPIN      7
`define SSW_IN_RST_VAL     8'hA8

`endif

// File: pkg/ssw_pkg.sv
// types of the supply supervisor and watchdog
// assumes the constants header is included by the design file
package ssw_pkg;

    typedef enum logic [1:0] {
        SSW_SUPPLY_LOW,
        SSW_PULSE,
        SSW_RUN
    } ssw_state_e;

    typedef struct packed {
        logic [7:0]  s1;
        logic [7:0]  s2;
        logic [7:0]  s3;
        logic [7:0]  filt;
        logic        strobe_prev;
        logic        osc_prev;
        ssw_state_e  state;
        logic        pu;
        logic [31:0] pulse_cnt;
        logic [31:0] wd_cnt;
        logic        first;
        logic        wdflag_n;
        logic        rst_act;
        logic        supply_low;
        logic [31:0] pb_cnt;
        logic [31:0] smp_cnt;
        logic [1:0]  low_cnt;
        logic        nmi_n;
        logic        nmi_oe;
        logic        powered;
        logic        mode_ext;
        logic        mode_osc_in;
        logic        wd_dis;
        logic        force_req;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  awaddr;
        logic [1:0]  wbits;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ssw_state_s;

endpackage

// File: tb/ssw_host.sv
// host model: pulls the strobe low at a commanded gap while out of reset
// assumes the bench raises i_kick_en only when kicks are wanted
`timescale 1ns/1ps

module ssw_host (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic        i_kick_en,
    input  wire logic [15:0] i_gap,
    output logic             o_strobe_n
);
    logic [15:0] cnt_q;

    // a held processor runs no code, so no kicks during reset
    always @(posedge i_mclk) begin
        if (i_reset || !i_kick_en) begin
            cnt_q <= 16'h0000;
            o_strobe_n <= 1'b1;
        end else begin
            cnt_q <= (cnt_q == i_gap) ? 16'h0000 : cnt_q + 16'h0001;
            // low for four cycles so the input filter keeps it
            o_strobe_n <= (cnt_q > 16'h0003);
        end
    end
endmodule // ssw_host

// File: tb/supply_supervisor_watchdog_bench.sv
// bench: host model, axi-lite master tasks and the scenario sequence
// assumes shortened timing parameters so every period is a few hundred cycles at most
`timescale 1ns/1ps
`include "ssw_params.svh"
`define chk(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module supply_supervisor_watchdog_bench;
    logic        clk = 1'b0, nrst = 1'b0, sup = 1'b0, sns = 1'b0, bat = 1'b1, sopen = 1'b0;
    logic        osc_in = 1'b0, osc_sel = 1'b1, pb_n = 1'b1, kick = 1'b0, ext_on = 1'b0;
    logic [2:0]  ediv = 3'h0;
    logic [15:0] gap = 16'h001E;
    // shortened timings so each period is a few hundred cycles at most
    localparam logic [31:0] TPU = 32'h28, WD_LONG = 32'hC8, WD_SHORT = 32'h3C, RST_INT = 32'h14;
    localparam logic [31:0] SMP = 32'h8, PB = 32'hA, EXT_FIRST = 32'h28, EXT_OTHER = 32'hA, EXT_RST = 32'h5;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        strobe_n, rst_n_out, rst_n_oe, rst, slow, wdf_n, nmi_n, nmi_oe;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          n_fail = 0, num_checks = 0;

    always #2 clk = ~clk;

    // external timing clock, eight system cycles a period
    always @(posedge clk) ediv <= ediv + 3'h1;

    ssw_host ssw_host_inst (.i_mclk(clk), .i_reset(rst), .i_kick_en(kick), .i_gap(gap),
        .o_strobe_n(strobe_n));

    // reset pin: pushbutton and the device's own pull-down share the pulled-up wire
    ssw_top #(.P_TPU_CYC(TPU), .P_WD_LONG_CYC(WD_LONG), .P_WD_SHORT_CYC(WD_SHORT), .P_RST_INT_CYC(RST_INT),
        .P_SAMPLE_CYC(SMP), .P_PB_CYC(PB), .P_EXT_FIRST(EXT_FIRST), .P_EXT_OTHER(EXT_OTHER),
        .P_EXT_RST(EXT_RST)) ssw_top_inst (
        .i_mclk(clk), .i_nrst(nrst), .i_supply_ok(sup), .i_sense_ok(sns), .i_above_battery(bat),
        .i_strobe_n(strobe_n), .i_strobe_open(sopen), .i_osc_input(ext_on ? ediv[2] : osc_in),
        .i_osc_select(osc_sel),
        .i_reset_n_in(pb_n & ~rst_n_oe), .o_reset_n_out(rst_n_out), .o_reset_n_oe(rst_n_oe), .o_reset(rst),
        .o_supply_low_flag(slow), .o_watchdog_flag_n(wdf_n), .o_nmi_n(nmi_n), .o_nmi_oe(nmi_oe),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: pick = rst;
            1: pick = slow;
            2: pick = wdf_n;
            3: pick = nmi_n;
            default: pick = nmi_oe;
        endcase
    endfunction

    // n counts edges until the output shows v; running out ends the run
    task automatic wait_val(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (pick(k) !== v) begin
            n_fail++;
            $display("CHECK FAILED wait %0d exp %0h got %0h", k, v, pick(k));
            wrap_up();
        end
    endtask

    task automatic hold_chk(input int k, input logic v, input int cyc);
        repeat (cyc) begin
            @(posedge clk);
            `chk("hold", v, pick(k))
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] dv, output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) begin n_fail++; wrap_up(); end
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) begin n_fail++; wrap_up(); end
        @(posedge clk);
    endtask

    initial begin
        int n;
        logic [31:0] d;
        logic [1:0] r;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `chk("rst", 1'b1, rst)
        `chk("low", 1'b1, slow)
        `chk("wdf", 1'b0, wdf_n)
        `chk("rst pin", 1'b0, rst_n_out)
        hold_chk(3, 1'b1, 60);
        sns <= 1'b1;
        sup <= 1'b1;
        wait_val(1, 1'b0, 12, n);
        `chk("rst held", 1'b1, rst)
        wait_val(0, 1'b0, 60, n);
        `chk("stretch", 1'b1, n inside {[30:45]})
        `chk("nmi oe", 1'b1, nmi_oe)
        wait_val(0, 1'b1, 260, n);
        `chk("first", 1'b1, n inside {[190:210]})
        `chk("wdf", 1'b0, wdf_n)
        `chk("oe", 1'b1, rst_n_oe)
        wait_val(0, 1'b0, 40, n);
        `chk("pulse", 1'b1, n inside {[16:24]})
        hold_chk(2, 1'b0, 20);
        kick <= 1'b1;
        wait_val(2, 1'b1, 12, n);
        hold_chk(0, 1'b0, 300);
        kick <= 1'b0;
        wait_val(0, 1'b1, 80, n);
        `chk("short", 1'b1, n inside {[25:70]})
        wait_val(0, 1'b0, 40, n);
        osc_in <= 1'b1;
        kick <= 1'b1;
        repeat (10) @(posedge clk);
        kick <= 1'b0;
        wait_val(0, 1'b1, 260, n);
        `chk("long", 1'b1, n inside {[180:205]})
        wait_val(0, 1'b0, 40, n);
        osc_in <= 1'b0;
        sopen <= 1'b1;
        gap <= 16'h0014;
        hold_chk(0, 1'b0, 300);
        axi_rd(`SSW_OFF_WDCNT, d, r);
        `chk("wdcnt", 32'h0, d)
        sopen <= 1'b0;
        kick <= 1'b1;
        axi_rd(4'hC, d, r);
        `chk("bad rd", `SSW_RESP_SLVERR, r)
        `chk("bad data", 32'h0, d)
        axi_wr(4'hC, 32'h1, r);
        `chk("bad wr", `SSW_RESP_SLVERR, r)
        wstrb <= 4'h0;
        axi_wr(`SSW_OFF_CTRL, 32'h1, r);
        axi_rd(`SSW_OFF_CTRL, d, r);
        `chk("strb", 32'h0, d)
        wstrb <= 4'hF;
        axi_wr(`SSW_OFF_CTRL, 32'h1, r);
        axi_rd(`SSW_OFF_CTRL, d, r);
        `chk("ctrl", 32'h1, d)
        axi_wr(`SSW_OFF_CTRL, 32'h2, r);
        wait_val(0, 1'b1, 12, n);
        wait_val(0, 1'b0, 40, n);
        axi_rd(`SSW_OFF_CTRL, d, r);
        `chk("ctrl", 32'h0, d)
        pb_n <= 1'b0;
        repeat (5) @(posedge clk);
        pb_n <= 1'b1;
        hold_chk(0, 1'b0, 30);
        pb_n <= 1'b0;
        wait_val(0, 1'b1, 30, n);
        `chk("press", 1'b1, n inside {[10:20]})
        pb_n <= 1'b1;
        wait_val(0, 1'b0, 40, n);
        for (int i = 0; i < 5; i++) begin
            sns <= 1'b0;
            hold_chk(3, 1'b1, 10);
            sns <= 1'b1;
            hold_chk(3, 1'b1, 6);
        end
        sns <= 1'b0;
        wait_val(3, 1'b0, 40, n);
        `chk("nmi", 1'b1, n inside {[16:34]})
        hold_chk(3, 1'b0, 20);
        sns <= 1'b1;
        wait_val(3, 1'b1, 8, n);
        osc_sel <= 1'b0;
        ext_on <= 1'b1;
        // count held at zero while the mode changes, so no stale count meets the shorter period
        sopen <= 1'b1;
        hold_chk(0, 1'b0, 8);
        sopen <= 1'b0;
        hold_chk(0, 1'b0, 400);
        kick <= 1'b0;
        wait_val(0, 1'b1, 120, n);
        `chk("ext per", 1'b1, n inside {[40:90]})
        wait_val(0, 1'b0, 60, n);
        `chk("ext rst", 1'b1, n inside {[30:50]})
        ext_on <= 1'b0;
        osc_sel <= 1'b1;
        sup <= 1'b0;
        wait_val(1, 1'b1, 10, n);
        `chk("rst", 1'b1, rst)
        `chk("wdf", 1'b0, wdf_n)
        hold_chk(0, 1'b1, 100);
        bat <= 1'b0;
        wait_val(4, 1'b0, 10, n);
        wrap_up();
    end
endmodule // supply_supervisor_watchdog_bench
